// ===== hw/dac_ctrl_pkg.sv
// Constants and types shared by the converter control block.
package dac_ctrl_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] CONTROL_OFFSET = 8'h00; // Control register.
	localparam logic [7:0] SOFTWARE_TRIGGER_BIT_OFFSET = 8'h04; // Software trigger bits.
	localparam logic [7:0] CH1_HELD_OFFSET = 8'h08; // Channel 1 held data.
	localparam logic [7:0] CH2_HELD_OFFSET = 8'h0c; // Channel 2 held data.
	localparam logic [7:0] CH1_OUT_OFFSET = 8'h10; // Channel 1 output value.
	localparam logic [7:0] CH2_OUT_OFFSET = 8'h14; // Channel 2 output value.

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int CH1_FIELD_LSB = 0; // Channel 1 fields start here.
	localparam int CH2_FIELD_LSB = 16; // Channel 2 fields start here.
	localparam int CH_FIELD_WIDTH = 13; // Bits per channel field group.
	localparam int CH2_DMA_BIT = 28; // Channel 2 DMA request enable.
	localparam logic [31:0] CONTROL_WRITE_MASK = 32'h1fff_1fff; // Writable bits.
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000; // Control reset.
	localparam logic [11:0] HELD_RESET = 12'h000; // Held data reset.
	localparam logic [11:0] NOISE_PRELOAD = 12'haaa; // Noise register seed.
	localparam logic [3:0] MASK_FULL_CODE = 4'hb; // Codes from here pass 12 bits.

	// ****************************************
	// Timing counts in clock cycles
	// ****************************************
	localparam int HW_TRIGGER_DELAY_CYCLES = 3; // Timer or line trigger.
	localparam int SW_TRIGGER_DELAY_CYCLES = 1; // Software trigger.

	// Wave generator modes.
	typedef enum logic [1:0] {
		WAVE_OFF = 2'b00,
		WAVE_NOISE = 2'b01,
		WAVE_TRIANGLE = 2'b10,
		WAVE_TRIANGLE_ALT = 2'b11
	} wave_mode_t;

	// Defined trigger source codes; other codes select nothing.
	localparam logic [2:0] TSEL_TIMER_A = 3'h1;
	localparam logic [2:0] TSEL_TIMER_B = 3'h4;
	localparam logic [2:0] TSEL_TIMER_C = 3'h5;
	localparam logic [2:0] TSEL_EXT_LINE9 = 3'h6;
	localparam logic [2:0] TSEL_SOFTWARE = 3'h7;

	// Triangle counter direction.
	typedef enum logic {
		TRI_UP = 1'b0,
		TRI_DOWN = 1'b1
	} tri_dir_t;

	// One channel's control fields, in register bit order.
	typedef struct packed {
		logic dma_request_enable;
		logic [3:0] mask_amplitude_select;
		wave_mode_t wave_generator_select;
		logic [2:0] trigger_source_select;
		logic trigger_enable;
		logic output_buffer_disable;
		logic channel_enable;
	} ch_ctrl_t;

	// Hardware trigger inputs.
	typedef struct packed {
		logic ext_line9;
		logic timer_c;
		logic timer_b;
		logic timer_a;
	} trig_src_t;

endpackage : dac_ctrl_pkg

// ===== hw/dac_trigger_unit.sv
// Trigger source selection, edge detection and delay for one channel.
`timescale 1ns/10ps
module dac_trigger_unit (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [2:0] trigger_source_select,
	input wire logic trigger_enable,
	input wire dac_ctrl_pkg::trig_src_t sources,
	input wire logic software_trigger_bit,
	output logic fire,
	output logic hw_fire
);
	localparam int STAGES = dac_ctrl_pkg::HW_TRIGGER_DELAY_CYCLES - 1;

	logic src_level; // Level of the selected hardware source.
	logic src_prev_reg; // Level one cycle earlier.
	logic [STAGES-1:0] pipe_reg; // Delay line for hardware edges.
	logic edge_seen; // Rising edge on the selected source.

	// Pick the hardware source; reserved codes select nothing.
	always_comb begin
		case (trigger_source_select)
			dac_ctrl_pkg::TSEL_TIMER_A: src_level = sources.timer_a;
			dac_ctrl_pkg::TSEL_TIMER_B: src_level = sources.timer_b;
			dac_ctrl_pkg::TSEL_TIMER_C: src_level = sources.timer_c;
			dac_ctrl_pkg::TSEL_EXT_LINE9: src_level = sources.ext_line9;
			default: src_level = 1'b0;
		endcase
	end

	// Remember the previous level for edge detection.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= src_level;
		end
	end

	assign edge_seen = trigger_enable && src_level && !src_prev_reg;

	// Delay the edge so the output loads three edges after it.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pipe_reg <= '0;
		end else begin
			pipe_reg <= {pipe_reg[STAGES-2:0], edge_seen};
		end
	end

	assign hw_fire = pipe_reg[STAGES-1];
	// Software trigger acts in the cycle after its bit is set.
	assign fire = hw_fire || (trigger_enable && software_trigger_bit
		&& trigger_source_select == dac_ctrl_pkg::TSEL_SOFTWARE);

	property p_edge_delay;
		@(posedge ref_clk) disable iff (!reset_n)
		edge_seen |-> ##2 hw_fire;
	endproperty
	a_edge_delay: assert property (p_edge_delay) else $error("edge not delayed by two");

endmodule : dac_trigger_unit

// ===== hw/dac_wave_unit.sv
// Noise and triangle generator with masking for one channel.
`timescale 1ns/10ps
module dac_wave_unit (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire dac_ctrl_pkg::wave_mode_t wave_generator_select,
	input wire logic [3:0] mask_amplitude_select,
	input wire logic step,
	input wire logic [11:0] held_data_value,
	output logic [11:0] wave_sum
);
	logic [11:0] pseudo_random_register; // Noise shift register.
	logic [11:0] tri_count_reg; // Triangle counter.
	dac_ctrl_pkg::tri_dir_t tri_dir_reg; // Triangle direction.
	logic [11:0] mask; // Unmasked bits, also the triangle peak.
	logic [11:0] wave_add; // Value added to the held data.
	logic [12:0] full_sum; // Sum with carry.
	logic feedback; // Noise feedback bit.

	// Code n passes bits n..0; large codes pass all twelve.
	assign mask = (mask_amplitude_select >= dac_ctrl_pkg::MASK_FULL_CODE) ? 12'hfff
		: 12'((13'h002 << mask_amplitude_select) - 13'h001);

	// Noise register: twelve-bit shift with feedback taps.
	assign feedback = pseudo_random_register[11] ^ pseudo_random_register[5]
		^ pseudo_random_register[3] ^ pseudo_random_register[0];
	always_ff @(posedge ref_clk) begin
		if (!reset_n || wave_generator_select == dac_ctrl_pkg::WAVE_OFF) begin
			pseudo_random_register <= dac_ctrl_pkg::NOISE_PRELOAD;
		end else if (step && wave_generator_select == dac_ctrl_pkg::WAVE_NOISE) begin
			if (pseudo_random_register == 12'h000) begin
				pseudo_random_register <= 12'h001;
			end else begin
				pseudo_random_register <= {pseudo_random_register[10:0], feedback};
			end
		end
	end

	// Triangle counter: up to the peak, down to zero, repeat.
	always_ff @(posedge ref_clk) begin
		if (!reset_n || wave_generator_select == dac_ctrl_pkg::WAVE_OFF) begin
			tri_count_reg <= 12'h000;
			tri_dir_reg <= dac_ctrl_pkg::TRI_UP;
		end else if (step && wave_generator_select[1]) begin
			case (tri_dir_reg)
				dac_ctrl_pkg::TRI_UP: begin
					if (tri_count_reg >= mask) begin
						tri_dir_reg <= dac_ctrl_pkg::TRI_DOWN;
						tri_count_reg <= tri_count_reg - 12'h001;
					end else begin
						tri_count_reg <= tri_count_reg + 12'h001;
					end
				end
				dac_ctrl_pkg::TRI_DOWN: begin
					if (tri_count_reg == 12'h000) begin
						tri_dir_reg <= dac_ctrl_pkg::TRI_UP;
						tri_count_reg <= 12'h001;
					end else begin
						tri_count_reg <= tri_count_reg - 12'h001;
					end
				end
				default: tri_dir_reg <= dac_ctrl_pkg::TRI_UP;
			endcase
		end
	end

	// Select what is added; the upper mode bit alone means triangle.
	always_comb begin
		if (wave_generator_select[1]) begin
			wave_add = tri_count_reg;
		end else if (wave_generator_select == dac_ctrl_pkg::WAVE_NOISE) begin
			wave_add = pseudo_random_register & mask;
		end else begin
			wave_add = 12'h000;
		end
	end

	assign full_sum = {1'b0, held_data_value} + {1'b0, wave_add};
	assign wave_sum = full_sum[11:0];

	property p_no_lockup;
		@(posedge ref_clk) disable iff (!reset_n)
		step && wave_generator_select == dac_ctrl_pkg::WAVE_NOISE |=> pseudo_random_register != 12'h000;
	endproperty
	a_no_lockup: assert property (p_no_lockup) else $error("noise register stuck at zero");

	property p_tri_up;
		@(posedge ref_clk) disable iff (!reset_n)
		step && wave_generator_select[1] && tri_dir_reg == dac_ctrl_pkg::TRI_UP
			&& tri_count_reg < mask |=> tri_count_reg == $past(tri_count_reg) + 12'h001;
	endproperty
	a_tri_up: assert property (p_tri_up) else $error("triangle failed to count up");

	property p_noise_mask;
		@(posedge ref_clk) disable iff (!reset_n)
		wave_generator_select == dac_ctrl_pkg::WAVE_NOISE
			&& mask_amplitude_select < dac_ctrl_pkg::MASK_FULL_CODE
			|-> (wave_add >> (mask_amplitude_select + 4'h1)) == 12'h000;
	endproperty
	a_noise_mask: assert property (p_noise_mask) else $error("noise passes masked bits");

	property p_off_reset;
		@(posedge ref_clk) disable iff (!reset_n)
		wave_generator_select == dac_ctrl_pkg::WAVE_OFF |=> tri_count_reg == 12'h000
			|| wave_generator_select != dac_ctrl_pkg::WAVE_OFF;
	endproperty
	a_off_reset: assert property (p_off_reset) else $error("off mode left counter running");

endmodule : dac_wave_unit

// ===== hw/dac_channel_control_register.sv
// Control register and output path of the two-channel converter.
`timescale 1ns/10ps

// Overview of operation
// - DMA enable bit gates channel DMA requests.
// - Mask field: noise width or triangle peak.
// - Code n passes n..0; eleven up all.
// - Mode 00 stops and resets both generators.
// - Mode 01 adds masked noise to data.
// - Upper mode bit set selects triangle generator.
// - Codes 001, 100, 101 pick three timers.
// - 110 picks external line, 111 software bit.
// - Trigger enabled: output loads three cycles after a hardware edge.
// - Trigger disabled: output follows data next cycle.
// - Fields read back and reset to zero.
// - Hardware sources act on rising edges.
// - Software trigger updates next cycle, self-clears.
// - Triangle counts up to peak, down, repeats.
// - Noise seeds 0xaaa and never sticks zero.
module dac_channel_control_register (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire dac_ctrl_pkg::trig_src_t trigger_sources,
	output logic [11:0] ch1_output_value,
	output logic [11:0] ch2_output_value,
	output logic ch1_dma_request,
	output logic ch2_dma_request,
	output dac_ctrl_pkg::ch_ctrl_t ch1_control,
	output dac_ctrl_pkg::ch_ctrl_t ch2_control
);

	// ****************************************
	// Storage
	// ****************************************

	// Control register; only the field bits are ever set.
	logic [31:0] control_reg;

	// Software trigger bits, one per channel; they last one cycle.
	logic [1:0] software_trigger_bit_reg;

	// Held data for each channel.
	logic [11:0] held_data_reg [2];

	// Output value of each channel.
	logic [11:0] output_value_reg [2];

	// DMA request pulse of each channel.
	logic [1:0] dma_request_reg;

	// Read data register, valid the cycle after a read strobe.
	logic [31:0] rdata_reg;

	// Read data selected from the address.
	logic [31:0] rdata_next;

	// Decoded field groups of each channel.
	dac_ctrl_pkg::ch_ctrl_t ch_ctrl [2];

	// Update strobe from the trigger path of each channel.
	logic [1:0] fire;

	// Hardware trigger strobe of each channel, for DMA.
	logic [1:0] hw_fire;

	// Held data with the wave added, per channel.
	logic [11:0] wave_sum [2];

	// Write strobes per register.
	logic wr_control;
	logic wr_software_trigger_bit;
	logic wr_held1;
	logic wr_held2;

	// ****************************************
	// Address decode
	// ****************************************

	// Each write strobe hits at most one register.
	// Unmapped offsets raise no strobe, so such writes are lost.
	assign wr_control = reg_write && reg_addr == dac_ctrl_pkg::CONTROL_OFFSET;
	assign wr_software_trigger_bit = reg_write && reg_addr == dac_ctrl_pkg::SOFTWARE_TRIGGER_BIT_OFFSET;
	assign wr_held1 = reg_write && reg_addr == dac_ctrl_pkg::CH1_HELD_OFFSET;
	assign wr_held2 = reg_write && reg_addr == dac_ctrl_pkg::CH2_HELD_OFFSET;

	// ****************************************
	// Control register
	// ****************************************

	// Writes keep only field bits, so reserved bits stay zero.
	// Software cannot set bits 31:29 or 15:13 by any write.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			control_reg <= dac_ctrl_pkg::CONTROL_RESET;
		end else if (wr_control) begin
			control_reg <= reg_wdata & dac_ctrl_pkg::CONTROL_WRITE_MASK;
		end
	end

	// Both channels use the same field order at their own offset.
	assign ch_ctrl[0] = dac_ctrl_pkg::ch_ctrl_t'(
		control_reg[dac_ctrl_pkg::CH1_FIELD_LSB +: dac_ctrl_pkg::CH_FIELD_WIDTH]);
	assign ch_ctrl[1] = dac_ctrl_pkg::ch_ctrl_t'(
		control_reg[dac_ctrl_pkg::CH2_FIELD_LSB +: dac_ctrl_pkg::CH_FIELD_WIDTH]);

	// The field groups drive the analog controls directly.
	assign ch1_control = ch_ctrl[0];
	assign ch2_control = ch_ctrl[1];

	// ****************************************
	// Software trigger
	// ****************************************

	// A written one lasts one cycle, then hardware clears it.
	// A new write in the clearing cycle keeps the bit set.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			software_trigger_bit_reg <= 2'h0;
		end else if (wr_software_trigger_bit) begin
			software_trigger_bit_reg <= reg_wdata[1:0];
		end else begin
			software_trigger_bit_reg <= 2'h0;
		end
	end

	// ****************************************
	// Held data
	// ****************************************

	// Held data take the low twelve bits of a write.
	// The upper bits of the word carry nothing and are dropped.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			held_data_reg[0] <= dac_ctrl_pkg::HELD_RESET;
			held_data_reg[1] <= dac_ctrl_pkg::HELD_RESET;
		end else begin
			if (wr_held1) begin
				held_data_reg[0] <= reg_wdata[11:0];
			end
			if (wr_held2) begin
				held_data_reg[1] <= reg_wdata[11:0];
			end
		end
	end

	// ****************************************
	// Channel trigger and wave paths
	// ****************************************

	for (genvar ch = 0; ch < 2; ch++) begin : g_channel

		// Trigger selection, edge detection and delay.
		dac_trigger_unit u_trigger (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.trigger_source_select(ch_ctrl[ch].trigger_source_select),
			.trigger_enable(ch_ctrl[ch].trigger_enable),
			.sources(trigger_sources),
			.software_trigger_bit(software_trigger_bit_reg[ch]),
			.fire(fire[ch]),
			.hw_fire(hw_fire[ch])
		);

		// Noise and triangle generator.
		dac_wave_unit u_wave (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.wave_generator_select(ch_ctrl[ch].wave_generator_select),
			.mask_amplitude_select(ch_ctrl[ch].mask_amplitude_select),
			.step(fire[ch]),
			.held_data_value(held_data_reg[ch]),
			.wave_sum(wave_sum[ch])
		);

		// Output value: follows held data, or loads on a trigger.
		// Clearing the trigger enable hands the output back to held data.
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				output_value_reg[ch] <= dac_ctrl_pkg::HELD_RESET;
			end else if (!ch_ctrl[ch].trigger_enable) begin
				output_value_reg[ch] <= held_data_reg[ch];
			end else if (fire[ch]) begin
				output_value_reg[ch] <= wave_sum[ch];
			end
		end

		// A hardware trigger raises a DMA request if enabled.
		// A software trigger never asks for DMA.
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				dma_request_reg[ch] <= 1'b0;
			end else begin
				dma_request_reg[ch] <= hw_fire[ch] && ch_ctrl[ch].dma_request_enable;
			end
		end
	end

	assign ch1_output_value = output_value_reg[0];
	assign ch2_output_value = output_value_reg[1];
	assign ch1_dma_request = dma_request_reg[0];
	assign ch2_dma_request = dma_request_reg[1];

	// ****************************************
	// Register read
	// ****************************************

	// Unmapped addresses read zero.
	// Output values are read-only; writes to their offsets do nothing.
	always_comb begin
		case (reg_addr)
			dac_ctrl_pkg::CONTROL_OFFSET: rdata_next = control_reg;
			dac_ctrl_pkg::SOFTWARE_TRIGGER_BIT_OFFSET: rdata_next = {30'h0, software_trigger_bit_reg};
			dac_ctrl_pkg::CH1_HELD_OFFSET: rdata_next = {20'h0, held_data_reg[0]};
			dac_ctrl_pkg::CH2_HELD_OFFSET: rdata_next = {20'h0, held_data_reg[1]};
			dac_ctrl_pkg::CH1_OUT_OFFSET: rdata_next = {20'h0, output_value_reg[0]};
			dac_ctrl_pkg::CH2_OUT_OFFSET: rdata_next = {20'h0, output_value_reg[1]};
			default: rdata_next = 32'h0;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	// Zero between reads keeps stale data off the bus.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdata_reg <= 32'h0;
		end else if (reg_read) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 32'h0;
		end
	end

	assign reg_rdata = rdata_reg;

	// ****************************************
	// Checks
	// ****************************************

	// DMA requests only while enabled.
	property p_dma_gate;
		@(posedge ref_clk) disable iff (!reset_n)
		ch2_dma_request |-> $past(control_reg[dac_ctrl_pkg::CH2_DMA_BIT]) && $past(hw_fire[1]);
	endproperty
	a_dma_gate: assert property (p_dma_gate) else $error("DMA request while disabled");

	// A timer edge loads the output three edges later.
	property p_timer_delay;
		@(posedge ref_clk) disable iff (!reset_n)
		ch_ctrl[1].trigger_enable && ch_ctrl[1].trigger_source_select == dac_ctrl_pkg::TSEL_TIMER_A
			&& trigger_sources.timer_a && !$past(trigger_sources.timer_a) && !wr_control
			&& !$past(wr_control) |-> ##2 fire[1];
	endproperty
	a_timer_delay: assert property (p_timer_delay) else $error("timer edge not acted on");

	// An external line edge loads the output value three edges later.
	property p_line_load;
		@(posedge ref_clk) disable iff (!reset_n)
		ch_ctrl[1].trigger_enable && ch_ctrl[1].trigger_source_select
			== dac_ctrl_pkg::TSEL_EXT_LINE9 && $rose(trigger_sources.ext_line9)
			&& !wr_control && !$past(wr_control) ##1 !wr_control[*2]
			|=> ch2_output_value == $past(wave_sum[1]);
	endproperty
	a_line_load: assert property (p_line_load) else $error("line trigger load wrong");

	// Without trigger the output copies held data a cycle later.
	property p_follow;
		@(posedge ref_clk) disable iff (!reset_n)
		!ch_ctrl[1].trigger_enable |=> ch2_output_value == $past(held_data_reg[1]);
	endproperty
	a_follow: assert property (p_follow) else $error("output did not follow data");

	// Control writes read back with reserved bits cleared.
	property p_readback;
		@(posedge ref_clk) disable iff (!reset_n)
		wr_control ##1 (reg_read && reg_addr == dac_ctrl_pkg::CONTROL_OFFSET && !reg_write)
			|=> reg_rdata == ($past(reg_wdata, 2) & dac_ctrl_pkg::CONTROL_WRITE_MASK);
	endproperty
	a_readback: assert property (p_readback) else $error("control readback mismatch");

	// Reserved bits never hold a one.
	property p_reserved;
		@(posedge ref_clk) disable iff (!reset_n)
		wr_control |=> control_reg[31:29] == 3'h0 && control_reg[15:13] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	// The software trigger bit clears itself.
	property p_sw_clear;
		@(posedge ref_clk) disable iff (!reset_n)
		software_trigger_bit_reg[1] && !wr_software_trigger_bit |=> !software_trigger_bit_reg[1];
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("software trigger stuck");

	// A selected software trigger loads the output next edge.
	property p_sw_load;
		@(posedge ref_clk) disable iff (!reset_n)
		software_trigger_bit_reg[1] && ch_ctrl[1].trigger_enable
			&& ch_ctrl[1].trigger_source_select == dac_ctrl_pkg::TSEL_SOFTWARE
			|=> ch2_output_value == $past(wave_sum[1]);
	endproperty
	a_sw_load: assert property (p_sw_load) else $error("software trigger load wrong");

	// Channel 1 fields sit in the low half.
	property p_mirror;
		@(posedge ref_clk) disable iff (!reset_n)
		wr_control |=> ch1_control.trigger_enable == $past(reg_wdata[2])
			&& ch2_control.trigger_enable == $past(reg_wdata[18]);
	endproperty
	a_mirror: assert property (p_mirror) else $error("field placement wrong");

	// Unmapped reads return zero.
	property p_unmapped;
		@(posedge ref_clk) disable iff (!reset_n)
		reg_read && reg_addr > dac_ctrl_pkg::CH2_OUT_OFFSET |=> reg_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// Channel 1 requests follow its own enable bit only.
	property p_ch1_dma_gate;
		@(posedge ref_clk) disable iff (!reset_n)
		ch1_dma_request |-> $past(control_reg[dac_ctrl_pkg::CH1_FIELD_LSB
			+ dac_ctrl_pkg::CH_FIELD_WIDTH - 1]) && $past(hw_fire[0]);
	endproperty
	a_ch1_dma_gate: assert property (p_ch1_dma_gate) else $error("ch1 DMA while disabled");

	// Channel 1 copies its held data a cycle later too.
	property p_ch1_follow;
		@(posedge ref_clk) disable iff (!reset_n)
		!ch_ctrl[0].trigger_enable |=> ch1_output_value == $past(held_data_reg[0]);
	endproperty
	a_ch1_follow: assert property (p_ch1_follow) else $error("ch1 did not follow data");

	// A software trigger alone never raises a DMA request.
	property p_sw_no_dma;
		@(posedge ref_clk) disable iff (!reset_n)
		software_trigger_bit_reg[1] && !hw_fire[1] |=> !ch2_dma_request;
	endproperty
	a_sw_no_dma: assert property (p_sw_no_dma) else $error("software trigger raised DMA");

endmodule : dac_channel_control_register

// ===== verif/trigger_partner.sv
// Model of the timers, external line and DMA controller around the converter.
`timescale 1ns/10ps
module trigger_partner (
	input wire logic ref_clk,
	input wire logic [3:0] pulse_req,
	output dac_ctrl_pkg::trig_src_t trigger_sources,
	input wire logic ch2_dma_request,
	output int dma_count
);
	// All sources start low and no request has been seen.
	initial begin
		trigger_sources = '0;
		dma_count = 0;
	end
	// Each source follows its request one edge later, so a request pulse is a rising edge.
	always @(posedge ref_clk) begin
		trigger_sources <= dac_ctrl_pkg::trig_src_t'(pulse_req);
	end
	// The DMA side counts every request pulse that it accepts.
	always @(posedge ref_clk) begin
		if (ch2_dma_request === 1'b1) begin
			dma_count <= dma_count + 1;
		end
	end
endmodule : trigger_partner

// ===== verif/tb_dac_channel_control_register.sv
// Self-checking bench for the converter control register.
`timescale 1ns/10ps
module tb_dac_channel_control_register;
	// ****************************************
	// Signals and case table
	// ****************************************
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic [3:0] pulse_req = 4'h0;
	dac_ctrl_pkg::trig_src_t trigger_sources;
	logic [11:0] ch1_output_value, ch2_output_value, exp_out, tri_cnt;
	logic ch1_dma_request, ch2_dma_request, tri_down;
	dac_ctrl_pkg::ch_ctrl_t ch1_control, ch2_control;
	int dma_count, dma_before, n_errors = 0, comparisons = 0;
	// Trigger select, source index, DMA enable, and whether the output must load.
	typedef struct {logic [2:0] tsel; int src; logic dma; logic hit;} row_t;
	row_t rows [5] = '{'{3'h1, 0, 1'b1, 1'b1}, '{3'h4, 1, 1'b0, 1'b1},
		'{3'h5, 2, 1'b1, 1'b1}, '{3'h6, 3, 1'b1, 1'b1}, '{3'h0, 0, 1'b1, 1'b0}};
	always #20 ref_clk = ~ref_clk;
	dac_channel_control_register uut (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .trigger_sources(trigger_sources),
		.ch1_output_value(ch1_output_value), .ch2_output_value(ch2_output_value),
		.ch1_dma_request(ch1_dma_request), .ch2_dma_request(ch2_dma_request),
		.ch1_control(ch1_control), .ch2_control(ch2_control));
	trigger_partner far_side (.ref_clk(ref_clk), .pulse_req(pulse_req),
		.trigger_sources(trigger_sources), .ch2_dma_request(ch2_dma_request),
		.dma_count(dma_count));
	// ****************************************
	// Tasks
	// ****************************************
	// Compares one value and reports a difference at once.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One-cycle write strobe.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask : wr
	// One-cycle read strobe; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 chk(what, reg_rdata, exp);
	endtask : rd
	// Channel 2 control word with the trigger enabled.
	function automatic logic [31:0] ctl(logic dma, logic [3:0] m, logic [1:0] w, logic [2:0] t);
		return {3'h0, dma, m, w, t, 1'b1, 2'h0, 16'h0000};
	endfunction : ctl
	// Software trigger on channel 2; the output loads one cycle after the bit is set.
	task automatic swt(input logic [11:0] exp);
		wr(8'h04, 32'h0000_0002);
		@(posedge ref_clk);
		#1 chk("sw output", ch2_output_value, exp);
	endtask : swt
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	// The whole sequence takes well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		finish_test();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(8'h00, 32'h0, "control after reset");
		wr(8'h00, 32'hffff_ffff);
		rd(8'h00, 32'h1fff_1fff, "control all ones");
		chk("ch1 fields", ch1_control, 13'h1fff);
		chk("ch2 fields", ch2_control, 13'h1fff);
		// Write and read back to back, with no gap between the strobes.
		@(posedge ref_clk);
		reg_addr <= 8'h00;
		reg_wdata <= 32'h5a5a_a5a5;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1 chk("back to back readback", reg_rdata, 32'h1a5a_05a5);
		wr(8'h00, 32'h0);
		wr(8'h0c, 32'h0000_0123);
		wr(8'h08, 32'h0000_0456);
		@(posedge ref_clk);
		#1 chk("untriggered output", ch2_output_value, 12'h123);
		chk("ch1 untriggered output", ch1_output_value, 12'h456);
		$display("register and direct path test done");
		exp_out = 12'h123;
		// Each row sets one trigger select code and pulses one hardware source once.
		foreach (rows[i]) begin
			wr(8'h00, ctl(rows[i].dma, 4'h0, 2'b00, rows[i].tsel));
			wr(8'h0c, 32'h200 + i);
			dma_before = dma_count;
			@(posedge ref_clk);
			pulse_req <= 4'h1 << rows[i].src;
			@(posedge ref_clk);
			pulse_req <= 4'h0;
			repeat (2) @(posedge ref_clk);
			#1 chk("output before delay", ch2_output_value, exp_out);
			if (rows[i].hit) begin
				exp_out = 12'h200 + i;
			end
			@(posedge ref_clk);
			#1 chk("output after delay", ch2_output_value, exp_out);
			chk("dma pins", {ch1_dma_request, ch2_dma_request}, rows[i].dma & rows[i].hit);
			@(posedge ref_clk);
			#1 chk("dma pulses", dma_count - dma_before, rows[i].dma & rows[i].hit);
		end
		$display("hardware trigger test done");
		// Mode 11 with peak code 1 runs 0,1,2,3,2,1,0,1.
		wr(8'h00, ctl(1'b0, 4'h1, 2'b11, 3'h7));
		wr(8'h0c, 32'h0);
		tri_cnt = 12'h000;
		tri_down = 1'b0;
		for (int k = 0; k < 8; k++) begin
			swt(tri_cnt);
			if (!tri_down) begin
				tri_down = (tri_cnt == 12'h003);
				tri_cnt = tri_down ? tri_cnt - 12'h001 : tri_cnt + 12'h001;
			end else begin
				tri_down = (tri_cnt != 12'h000);
				tri_cnt = tri_down ? tri_cnt - 12'h001 : tri_cnt + 12'h001;
			end
		end
		rd(8'h04, 32'h0, "software bit cleared");
		$display("triangle test done");
		wr(8'h00, ctl(1'b0, 4'h0, 2'b00, 3'h7));
		wr(8'h0c, 32'h100);
		swt(12'h100);
		wr(8'h00, ctl(1'b0, 4'hb, 2'b01, 3'h7));
		swt(12'hbaa);
		swt(12'h655);
		wr(8'h00, ctl(1'b0, 4'h2, 2'b00, 3'h7));
		swt(12'h100);
		wr(8'h00, ctl(1'b0, 4'h2, 2'b01, 3'h7));
		swt(12'h102);
		rd(8'h40, 32'h0, "unmapped read");
		$display("noise test done");
		// Reset in mid-run clears the output and the control fields.
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		#1 chk("output after reset", ch2_output_value, 12'h000);
		rd(8'h00, 32'h0, "control after second reset");
		$display("second reset test done");
		finish_test();
	end
endmodule : tb_dac_channel_control_register
